// file: pof_defs.svh
`ifndef POF_DEFS_SVH
`define POF_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define POF_IDX_BANK_A   8'h07
`define POF_IDX_BANK_B   8'h0d
`define POF_IDX_CTRL     8'h87
`define POF_IDX_HOLD     8'h89
`define POF_IDX_STAT     8'hc8
`define POF_BANK_BYTES   6

// ==========================================================================
// Field positions
// ==========================================================================
`define POF_CTRL_RST     7
`define POF_CTRL_APPLY   6
`define POF_CTRL_FRZM    5
`define POF_CTRL_FRZV    4
`define POF_CTRL_RECALL  0
`define POF_HOLD_BIT     4
`define POF_STAT_BUSY    0
`define POF_STAT_RUN     1
`define POF_STAT_TMO     2
`define POF_STAT_WAIT    3
`define POF_FRAC_BITS    28

// ==========================================================================
// Factory defaults
// ==========================================================================
`define POF_DEF_HS       3'h0
`define POF_DEF_N1       7'h07
`define POF_DEF_M        38'h2bc011eb8

// ==========================================================================
// Timing and window
// ==========================================================================
`define POF_CLK_MHZ      100
`define POF_TIMEOUT_MS   10
`define POF_RECAL_US     1000
`define POF_WIN_NUM      49'h7
`define POF_WIN_DEN      49'h7d0

`endif

// file: pof_freq_ctrl.sv
`timescale 1ns/1ns
`include "pof_defs.svh"

// How it works
// - Output equals crystal times multiplier over dividers.
// - Oscillator must stay within 4.85 to 5.67 GHz; nothing here checks or clamps it.
// - Changes within 3500 ppm retune without interruption.
// - Larger changes recalibrate, stop output, new center.
// - Without hold, each multiplier byte applies at once.
// - Multiplier hold freezes applied value until cleared.
// - High-speed divider only 4,5,6,7,9,11.
// - Output divider is 1 or even up to 128.
// - Multiplier is 10.28 unsigned fixed point.
// - No apply within 10 ms after release reverts to defaults.
// - Apply sequence stops output, completes within 10 ms.
// - Reset restores readable factory default configuration.
// - Divider codes are value minus 4 and minus 1.
// - Registers carry one byte each.
module pof_freq_ctrl
  import pof_pkg::*;
#(
  parameter int        ADDR_W      = 12,
  parameter bit        STAB_7PPM   = 1'b0,
  parameter int        TIMEOUT_CYC = `POF_TIMEOUT_MS * 1000 * `POF_CLK_MHZ,
  parameter int        RECAL_CYC   = `POF_RECAL_US * `POF_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Crystal reference and generated clock
  input  wire logic              xtal_i,
  output logic                   clk_out_o
);

  localparam int BASE = STAB_7PPM ? `POF_BANK_BYTES : 0;
  localparam int TW   = $clog2(TIMEOUT_CYC + RECAL_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);
  localparam logic [TW-1:0] REC_LAST = TW'(RECAL_CYC - 1);

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[9:2];
  endfunction

  function automatic logic in_bank(input logic [7:0] i);
    in_bank = (i >= `POF_IDX_BANK_A) && (i < `POF_IDX_BANK_B + 8'h06);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = reg_idx(a);
    mapped = (a[ADDR_W-1:10] == '0) && (in_bank(i) || i == `POF_IDX_CTRL ||
             i == `POF_IDX_HOLD || i == `POF_IDX_STAT);
  endfunction

  function automatic logic [3:0] hs_val(input logic [2:0] c);
    unique case (c)
      3'h0: hs_val = 4'h4;
      3'h1: hs_val = 4'h5;
      3'h2: hs_val = 4'h6;
      3'h3: hs_val = 4'h7;
      3'h5: hs_val = 4'h9;
      3'h7: hs_val = 4'hb;
      default: hs_val = 4'h0;
    endcase
  endfunction

  function automatic logic n1_ok(input logic [6:0] c);
    n1_ok = (c == 7'h00) || c[0];
  endfunction

  function automatic logic [7:0] def_byte(input logic [2:0] k);
    logic [47:0] img;
    img = {`POF_DEF_HS, `POF_DEF_N1, `POF_DEF_M};
    def_byte = img[8'(47 - 8 * k) -: 8];
  endfunction

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0]  bank_q [0:2*`POF_BANK_BYTES-1];
  logic        aw_ok_q, w_ok_q, w_st0_q;
  logic [7:0]  w_idx_q, w_data_q;
  logic        w_map_q;
  logic        frz_m_q, frz_v_q, frz_dco_q, tmo_q;
  pof_state_e  st_q;
  logic [TW-1:0] tmr_q;
  pof_mult_t   app_m_q, ctr_m_q;
  logic [2:0]  app_hs_q;
  logic [6:0]  app_n1_q;

  logic        wr_fire, ar_fire, ctrl_wr, apply_req, rst_reg_p, recall_p, revert_p;
  logic        out_run, in_win, rec_done;
  logic [2:0]  act_hs;
  logic [6:0]  act_n1;
  pof_mult_t   act_m, diff_w;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_byte;

  // ==========================================================================
  // AXI4-Lite handshakes
  // ==========================================================================
  assign s_axi_awready = ce_i && !aw_ok_q && !s_axi_bvalid;
  assign s_axi_wready  = ce_i && !w_ok_q && !s_axi_bvalid;
  assign s_axi_arready = ce_i && !s_axi_rvalid;
  assign wr_fire       = ce_i && aw_ok_q && w_ok_q && !s_axi_bvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign ctrl_wr       = wr_fire && w_st0_q && w_idx_q == `POF_IDX_CTRL;
  assign apply_req     = ctrl_wr && w_data_q[`POF_CTRL_APPLY];
  assign rst_reg_p     = ctrl_wr && w_data_q[`POF_CTRL_RST];
  assign recall_p      = ctrl_wr && w_data_q[`POF_CTRL_RECALL];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_ok_q  <= 1'b0;
      w_idx_q  <= 8'h00;
      w_map_q  <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        w_idx_q <= reg_idx(s_axi_awaddr);
        w_map_q <= mapped(s_axi_awaddr);
      end else if (wr_fire) begin
        aw_ok_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      w_ok_q   <= 1'b0;
      w_data_q <= 8'h00;
      w_st0_q  <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q   <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_st0_q  <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_ok_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (ce_i) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map_q ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  assign rd_idx = reg_idx(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    if (in_bank(rd_idx)) begin
      rd_byte = bank_q[4'(rd_idx - `POF_IDX_BANK_A)];
    end else if (rd_idx == `POF_IDX_CTRL) begin
      rd_byte[`POF_CTRL_APPLY] = (st_q == ST_RECAL);
      rd_byte[`POF_CTRL_FRZM]  = frz_m_q;
      rd_byte[`POF_CTRL_FRZV]  = frz_v_q;
    end else if (rd_idx == `POF_IDX_HOLD) begin
      rd_byte[`POF_HOLD_BIT] = frz_dco_q;
    end else if (rd_idx == `POF_IDX_STAT) begin
      rd_byte[`POF_STAT_BUSY] = (st_q == ST_RECAL);
      rd_byte[`POF_STAT_RUN]  = out_run;
      rd_byte[`POF_STAT_TMO]  = tmo_q;
      rd_byte[`POF_STAT_WAIT] = (st_q == ST_WAIT_APPLY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (ce_i) begin
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, mapped(s_axi_araddr) ? rd_byte : 8'h00};
        s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h3;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration banks
  // ==========================================================================
  // Register reset, recall and the apply timeout all reload factory values.
  always_ff @(posedge clk_i) begin
    if (!rstn_i || rst_reg_p || recall_p || revert_p) begin
      for (int i = 0; i < 2 * `POF_BANK_BYTES; i++) begin
        bank_q[i] <= def_byte(3'(i % `POF_BANK_BYTES));
      end
    end else if (wr_fire && w_st0_q && in_bank(w_idx_q)) begin
      bank_q[4'(w_idx_q - `POF_IDX_BANK_A)] <= w_data_q;
    end
  end

  // Only the bank of this part's stability grade is ever decoded.
  assign act_hs = bank_q[BASE][7:5];
  assign act_n1 = {bank_q[BASE][4:0], bank_q[BASE+1][7:6]};
  assign act_m  = {bank_q[BASE+1][5:0], bank_q[BASE+2], bank_q[BASE+3],
                   bank_q[BASE+4], bank_q[BASE+5]};

  // ==========================================================================
  // Control bits
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rstn_i || rst_reg_p) begin
      frz_m_q   <= 1'b0;
      frz_v_q   <= 1'b0;
      frz_dco_q <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_wr) begin
        frz_m_q <= w_data_q[`POF_CTRL_FRZM];
        frz_v_q <= w_data_q[`POF_CTRL_FRZV];
      end
      if (wr_fire && w_st0_q && w_idx_q == `POF_IDX_HOLD) begin
        frz_dco_q <= w_data_q[`POF_HOLD_BIT];
      end
    end
  end

  // Timeout flag: a new timeout wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tmo_q <= 1'b0;
    end else if (ce_i) begin
      if (revert_p) begin
        tmo_q <= 1'b1;
      end else if (wr_fire && w_st0_q && w_idx_q == `POF_IDX_STAT &&
                   w_data_q[`POF_STAT_TMO]) begin
        tmo_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Frequency sequencer
  // ==========================================================================
  assign diff_w   = (act_m > ctr_m_q) ? act_m - ctr_m_q : ctr_m_q - act_m;
  assign in_win   = ({11'h0, diff_w} * `POF_WIN_DEN) <= ({11'h0, ctr_m_q} * `POF_WIN_NUM);
  assign out_run  = (st_q != ST_RECAL);
  assign rec_done = ce_i && st_q == ST_RECAL && tmr_q == REC_LAST;
  assign revert_p = ce_i && st_q == ST_WAIT_APPLY && tmr_q == TMO_LAST &&
                    !apply_req && !frz_dco_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q  <= ST_RUN;
      tmr_q <= '0;
    end else if (ce_i) begin
      tmr_q <= tmr_q + TW'(1);
      unique case (st_q)
        ST_RUN: begin
          tmr_q <= '0;
          if (frz_dco_q) begin
            st_q <= ST_FROZEN;
          end else if (apply_req) begin
            st_q <= ST_RECAL;
          end else if (!frz_m_q && act_m != app_m_q && !in_win) begin
            st_q <= ST_RECAL;
          end
        end
        ST_FROZEN: begin
          tmr_q <= '0;
          if (!frz_dco_q) begin
            st_q <= ST_WAIT_APPLY;
          end
        end
        ST_WAIT_APPLY: begin
          if (frz_dco_q) begin
            st_q <= ST_FROZEN;
          end else if (apply_req) begin
            st_q  <= ST_RECAL;
            tmr_q <= '0;
          end else if (tmr_q == TMO_LAST) begin
            st_q <= ST_RUN;
          end
        end
        ST_RECAL: begin
          if (tmr_q == REC_LAST) begin
            st_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Applied configuration. Dividers only move at a recalibration, and an
  // illegal divider code leaves the previous dividers in force.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      app_m_q  <= `POF_DEF_M;
      ctr_m_q  <= `POF_DEF_M;
      app_hs_q <= `POF_DEF_HS;
      app_n1_q <= `POF_DEF_N1;
    end else if (rec_done) begin
      app_m_q <= act_m;
      ctr_m_q <= act_m;
      if (hs_val(act_hs) != 4'h0 && n1_ok(act_n1)) begin
        app_hs_q <= act_hs;
        app_n1_q <= act_n1;
      end
    end else if (ce_i && st_q == ST_RUN && !frz_dco_q && !apply_req &&
                 !frz_m_q && in_win) begin
      app_m_q <= act_m;
    end
  end

  // The oscillator range limit is left to the programmer; nothing clamps it.
  pof_synth u_synth (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .xtal_i    (xtal_i),
    .run_i     (out_run),
    .mult_i    (app_m_q),
    .hs_val_i  (hs_val(app_hs_q)),
    .n1_val_i  ({1'b0, app_n1_q} + 8'h01),
    .clk_out_o (clk_out_o)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_enter_recal;
    $rose(st_q == ST_RECAL) && ce_i;
  endsequence

  sequence s_small_step;
    ce_i && st_q == ST_RUN && !frz_dco_q && !apply_req && !frz_m_q &&
      act_m != app_m_q && in_win;
  endsequence

  AST_SMALL_TRACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_small_step |=> (app_m_q == $past(act_m) && st_q == ST_RUN))
    else $error("Small change did not retune in place.");

  AST_HOLD_M: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (frz_m_q && st_q == ST_RUN && !rec_done) |=> $stable(app_m_q))
    else $error("Applied multiplier moved under hold.");

  AST_LARGE_RECAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && st_q == ST_RUN && !frz_dco_q && !frz_m_q && act_m != app_m_q && !in_win)
      |=> (st_q == ST_RECAL && !out_run))
    else $error("Large change did not start recalibration.");

  AST_RECAL_DONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rec_done |=> (st_q == ST_RUN && ctr_m_q == $past(act_m) && app_m_q == $past(act_m)))
    else $error("Recalibration did not finish with new center.");

  AST_RECAL_STOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_enter_recal |=> !clk_out_o)
    else $error("Output kept running during recalibration.");

  AST_TIMEOUT_REVERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    revert_p |=> (st_q == ST_RUN && tmo_q && bank_q[BASE+5] == def_byte(3'h5)))
    else $error("Apply timeout did not revert to defaults.");

  AST_APPLY_TAKEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && st_q == ST_WAIT_APPLY && apply_req && !frz_dco_q) |=> st_q == ST_RECAL)
    else $error("Apply after release was not taken.");

  AST_DIV_LEGAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hs_val(app_hs_q) != 4'h0 && n1_ok(app_n1_q)))
    else $error("Illegal divider in force.");

  AST_BANK_SEL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_fire && w_st0_q && in_bank(w_idx_q) && !revert_p &&
     (w_idx_q < 8'(`POF_IDX_BANK_A + BASE) || w_idx_q > 8'(`POF_IDX_BANK_A + BASE + 5)))
      |=> $stable(act_m))
    else $error("Inactive bank write changed the oscillator.");

  AST_POWERUP: assert property (@(posedge clk_i)
    (!rstn_i ##1 rstn_i) |-> (act_m == `POF_DEF_M && app_m_q == `POF_DEF_M))
    else $error("Defaults not restored by reset.");

endmodule // pof_freq_ctrl

// file: pof_pkg.sv
package pof_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FROZEN,
    ST_WAIT_APPLY,
    ST_RECAL
  } pof_state_e;

  typedef logic [37:0] pof_mult_t;

endpackage

// file: pof_synth.sv
`timescale 1ns/1ns
`include "pof_defs.svh"

module pof_synth
  import pof_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // Crystal reference pin
  input  wire logic        xtal_i,
  // Applied configuration
  input  wire logic        run_i,
  input  wire pof_mult_t   mult_i,
  input  wire logic [3:0]  hs_val_i,
  input  wire logic [7:0]  n1_val_i,
  // Output clock
  output logic             clk_out_o
);

  logic        x_s1_q;
  logic        x_s2_q;
  logic        x_s3_q;
  logic        edge_w;
  logic [11:0] prod_w;
  logic [39:0] mod_w;
  logic [39:0] phase_q;

  assign edge_w = x_s2_q & ~x_s3_q;
  assign prod_w = 12'(hs_val_i * n1_val_i);
  assign mod_w  = {prod_w, 28'h0};

  // ==========================================================================
  // Crystal synchroniser
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      x_s1_q <= 1'b0;
      x_s2_q <= 1'b0;
      x_s3_q <= 1'b0;
    end else if (ce_i) begin
      x_s1_q <= xtal_i;
      x_s2_q <= x_s1_q;
      x_s3_q <= x_s2_q;
    end
  end

  // ==========================================================================
  // Phase accumulator
  // ==========================================================================
  // Each rising crystal edge advances the phase by the multiplier; the modulus is the
  // divider product in the same fixed point, so the output runs at
  // crystal * multiplier / (divider product). Wraps are worked off one per
  // cycle, which the slow crystal edge rate leaves ample room for.
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i) begin
      phase_q   <= 40'h0;
      clk_out_o <= 1'b0;
    end else if (ce_i) begin
      if (edge_w && phase_q < mod_w) begin
        phase_q <= phase_q + {2'h0, mult_i};
      end else if (edge_w) begin
        phase_q <= phase_q + {2'h0, mult_i} - mod_w;
      end else if (phase_q >= mod_w) begin
        phase_q <= phase_q - mod_w;
      end
      clk_out_o <= (phase_q < mod_w) && (phase_q >= {1'b0, mod_w[39:1]});
    end
  end

  AST_PHASE_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && run_i && edge_w && phase_q < mod_w) |=>
      (!run_i || phase_q == $past(phase_q) + {2'h0, $past(mult_i)}))
    else $error("Phase did not advance by the multiplier.");

endmodule // pof_synth

// file: pof_xtal_model.sv
`timescale 1ns/1ns

// ==========================================================================
// Crystal reference source
// ==========================================================================
// The reference runs free while powered, so the source never stops.
module pof_xtal_model #(
  parameter int HALF_NS = 40
) (
  // Reference output
  output logic xtal_o
);
  initial begin
    xtal_o = 1'b0;
    forever #(HALF_NS) xtal_o = ~xtal_o;
  end
endmodule // pof_xtal_model

// file: tb_top.sv
`timescale 1ns/1ns

module tb_top;
  import pof_pkg::*;

  // ========================================================================
  // Signals
  // ========================================================================
  localparam int TMO = 200;
  localparam int RCL = 50;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, arready, bvalid, rvalid, clk_out_o, xtal;
  logic        bready = 1'b1, rready = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  int          errors = 0, compares = 0, n;
  logic        last;
  logic [7:0]  n_def [6] = '{8'h01, 8'hc2, 8'hbc, 8'h01, 8'h1e, 8'hb8};

  always #5 clk_i = ~clk_i;

  pof_xtal_model u_pof_xtal_model (.xtal_o(xtal));

  pof_freq_ctrl #(.TIMEOUT_CYC(TMO), .RECAL_CYC(RCL)) u_pof_freq_ctrl (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .xtal_i(xtal),
    .clk_out_o(clk_out_o));

  // ========================================================================
  // Compare and bus tasks
  // ========================================================================
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: data %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkr(input logic [1:0] g, input logic [1:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: response %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [11:0] ba(input int i);
    return 12'(i * 4);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    while (!(ad && wd)) begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    chkr(bresp, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                    input logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    chk(rdata[7:0] & m, e);
    chkr(rresp, r);
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ========================================================================
  // Tests
  // ========================================================================
  initial begin
    repeat (8000) @(posedge clk_i);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (n_def[i]) rd(ba(7 + i), 8'hff, n_def[i], 2'b00);
    rd(ba(18), 8'hff, 8'hb8, 2'b00);
    rd(ba(200), 8'h0f, 8'h02, 2'b00);
    rd(12'hc00, 8'hff, 8'h00, 2'b11);
    wr(12'hc00, 8'h5a, 2'b11);
    $display("test reset done");
    rd(ba(12), 8'hff, 8'hb8, 2'b00);
    wr(ba(12), 8'hc8, 2'b00);
    rd(ba(12), 8'hff, 8'hc8, 2'b00);
    wr(ba(135), 8'h20, 2'b00);
    rd(ba(135), 8'h20, 8'h20, 2'b00);
    wr(ba(11), 8'h1f, 2'b00);
    wr(ba(135), 8'h00, 2'b00);
    rd(ba(11), 8'hff, 8'h1f, 2'b00);
    wr(ba(18), 8'h11, 2'b00);
    rd(ba(18), 8'hff, 8'h11, 2'b00);
    $display("test small change done");
    rd(ba(7), 8'hff, 8'h01, 2'b00);
    wr(ba(137), 8'h10, 2'b00);
    wr(ba(7), 8'h81, 2'b00);
    wr(ba(9), 8'hd1, 2'b00);
    wr(ba(137), 8'h00, 2'b00);
    rd(ba(200), 8'h08, 8'h08, 2'b00);
    wr(ba(135), 8'h40, 2'b00);
    rd(ba(200), 8'h01, 8'h01, 2'b00);
    chk({7'h0, clk_out_o}, 8'h00);
    repeat (RCL + 20) @(posedge clk_i);
    rd(ba(200), 8'h09, 8'h00, 2'b00);
    n = 0;
    last = clk_out_o;
    repeat (200) begin
      @(posedge clk_i);
      if (clk_out_o !== last) n++;
      last = clk_out_o;
    end
    chk(8'(n > 0), 8'h01);
    rd(ba(9), 8'hff, 8'hd1, 2'b00);
    rd(ba(7), 8'hff, 8'h81, 2'b00);
    $display("test large change done");
    wr(ba(137), 8'h10, 2'b00);
    wr(ba(137), 8'h00, 2'b00);
    repeat (TMO + 30) @(posedge clk_i);
    rd(ba(200), 8'h04, 8'h04, 2'b00);
    rd(ba(9), 8'hff, 8'hbc, 2'b00);
    wr(ba(200), 8'h04, 2'b00);
    rd(ba(200), 8'h04, 8'h00, 2'b00);
    $display("test timeout done");
    wr(ba(12), 8'h55, 2'b00);
    wr(ba(135), 8'h80, 2'b00);
    rd(ba(12), 8'hff, 8'hb8, 2'b00);
    rd(ba(135), 8'h80, 8'h00, 2'b00);
    wr(ba(12), 8'h33, 2'b00);
    wr(ba(135), 8'h01, 2'b00);
    rd(ba(12), 8'hff, 8'hb8, 2'b00);
    $display("test register reset done");
    wrap_up();
  end

endmodule // tb_top
